//--- include/iec_pkg.sv
// Purpose : Shared constants, types and helpers of the interval/event counter
// Assumes : Word registers on a 32-bit AHB-Lite bus, low 12 address bits decoded
// Notes   : Control word layout follows iec_ctrl_t, enable in bit 0
package iec_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_PERIOD  = 12'h004;
    localparam logic [11:0] OFS_AUX1    = 12'h008;
    localparam logic [11:0] OFS_AUX2    = 12'h00C;
    localparam logic [11:0] OFS_AUX3    = 12'h010;
    localparam logic [11:0] OFS_COUNT   = 12'h014;
    localparam logic [11:0] OFS_OPTION  = 12'h018;
    localparam logic [11:0] OFS_MASK    = 12'h01C;

    // ------------------------------------------------------------------
    // Field layout, sizes and reset values
    // ------------------------------------------------------------------
    localparam int          AUX_N       = 3;
    localparam int          CTRL_W      = 9;
    localparam int          OVF_BIT     = 0;
    localparam logic [2:0]  MODE_INTERVAL = 3'h0;
    localparam logic [2:0]  MODE_EVENT    = 3'h1;
    localparam logic [1:0]  EDGE_NONE     = 2'h0;
    localparam logic [1:0]  EDGE_RISE     = 2'h1;
    localparam logic [1:0]  EDGE_FALL     = 2'h2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
    localparam logic [15:0] PERIOD_RST  = 16'h0000;
    localparam logic [15:0] AUX_RST     = 16'h0000;
    localparam logic [AUX_N-1:0] MASK_RST = 3'h0;
    localparam logic [15:0] CNT_IDLE    = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    localparam logic [15:0] CNT_ONE     = 16'h0001;
    localparam logic [2:0]  HSIZE_WORD  = 3'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] event_edge;          // Event input edge: none/rise/fall/both
        logic       capture_edge_sel_hi;
        logic       capture_edge_sel_lo;
        logic       ext_event_clock_sel;
        logic [2:0] mode_select_field;
        logic       count_enable_bit;
    } iec_ctrl_t;

    typedef struct packed {
        logic        wr;                 // One-cycle write strobe
        logic [11:0] addr;
        logic [31:0] wdata;
    } iec_bus_req_t;

    typedef enum logic [1:0] {
        IEC_IDLE,
        IEC_ARMED,
        IEC_RUN
    } iec_state_t;

    // Address compare used by write decode and read mux
    function automatic logic iec_hit(input logic [11:0] addr, input logic [11:0] ofs);
        return addr == ofs;
    endfunction

endpackage

//--- logic/iec_edge_sync.sv
// Purpose : Two-stage synchroniser and edge detector for the event input pin
// Assumes : Pin is asynchronous to sys_clk and slower than half its rate
// Notes   : Pulse appears three cycles after the pin edge
`timescale 1ns/100ps
`default_nettype none
module iec_edge_sync
    import iec_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       pin_in,
    input  wire logic [1:0] edge_sel,
    output var  logic       edge_pulse
);

    logic sync1;
    logic sync2;
    logic sync3;

    // ------------------------------------------------------------------
    // Synchroniser chain, first stage read only by the second
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Edge selection on the settled stages
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            edge_pulse <= 1'b0;
        end else begin
            case (edge_sel)
                EDGE_NONE: edge_pulse <= 1'b0;
                EDGE_RISE: edge_pulse <= sync2 & ~sync3;
                EDGE_FALL: edge_pulse <= ~sync2 & sync3;
                default:   edge_pulse <= sync2 ^ sync3;
            endcase
        end
    end

endmodule
`default_nettype wire

//--- logic/iec_ahb_slave.sv
// Purpose : AHB-Lite slave front end with one wait state per transfer
// Assumes : Single word transfers; hreadyout is fed back as hready
// Notes   : Writes commit at the end of the wait state, reads latch there
`timescale 1ns/100ps
`default_nettype none
module iec_ahb_slave
    import iec_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    input  wire logic [31:0]  rd_data,
    output var  iec_bus_req_t bus_req,
    output var  logic [31:0]  hrdata,
    output var  logic         hreadyout,
    output var  logic         hresp
);

    logic        pend;
    logic        pend_write;
    logic [11:0] pend_addr;

    // ------------------------------------------------------------------
    // Address phase capture and wait state
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend       <= 1'b0;
            pend_write <= 1'b0;
            pend_addr  <= 12'h000;
            hreadyout  <= 1'b1;
        end else if (hready && hsel && htrans[1]) begin
            pend       <= 1'b1;
            pend_write <= hwrite && (hsize == HSIZE_WORD); // Narrow writes dropped
            pend_addr  <= {haddr[11:2], 2'b00};
            hreadyout  <= 1'b0;
        end else if (pend) begin
            pend       <= 1'b0;
            hreadyout  <= 1'b1;
        end
    end

    // Read data latched at the end of the wait state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (pend && !pend_write) begin
            hrdata <= rd_data;
        end
    end

    // Response is always OKAY
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // Write strobe toward the register file
    assign bus_req.wr    = pend && pend_write;
    assign bus_req.addr  = pend_addr;
    assign bus_req.wdata = hwdata;

endmodule
`default_nettype wire

//--- logic/iec_timer.sv
// Purpose : 16-bit interval timer and external event counter with AHB registers
// Assumes : Internal count clock is sys_clk; event pin is asynchronous
// Notes   : Modes other than interval and event count leave the counter idle
//
// Behaviour
// (R1) Zero period: match every tick, count stays zero
// (R2) Full period clears at FFFFH without overflow
// (R3) Period write reaches buffer at once
// (R4) Lowered period wraps through FFFFH first
// (R5) Software stops counting before lowering period
// (R6) Aux below period: irq and toggle once per cycle
// (R7) Aux above period: no irq, output held
// (R8) Mode 001 counts event edges, no period output
// (R9) Event start: FFFFH to zero, load buffer
// (R10) Event match clears counter, raises irq
// (R11) Aux buffers and irqs work in event mode
// (R12) External clock only on event pin, capture off
// (R13) Software never sets zero period in event mode
// (R14) Interval mode plus event clock for output
// (R15) Event mode full period: no overflow flag
// (R16) Event mode lowered period wraps around
// (R17) Capture and option settings ignored in event mode
// (R18) Mode 000 counts the count clock
// (R19) Interval match clears, toggles, raises irq
// (R20) Enable low holds counter idle
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module iec_timer
    import iec_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output var  logic [31:0]       hrdata,
    output var  logic              hreadyout,
    output var  logic              hresp,
    input  wire logic              trigger_event_input,
    output var  logic              period_toggle_out,
    output var  logic [AUX_N-1:0]  aux_toggle_out,
    output var  logic              period_match_irq,
    output var  logic [AUX_N-1:0]  aux_match_irq,
    output var  logic              overflow_irq
);

    iec_bus_req_t                 bus_req;
    iec_ctrl_t                    ctrl;
    iec_state_t                   state;
    logic [15:0]                  period_compare_reg;
    logic [AUX_N-1:0][15:0]       aux_compare_regs;
    logic [15:0]                  period_buf;
    logic [AUX_N-1:0][15:0]       aux_buf;
    logic [15:0]                  cnt;
    logic                         overflow_flag;
    logic [AUX_N-1:0]             aux_match_mask_flags;
    logic [31:0]                  rd_data;
    logic                         ev_edge;
    logic                         is_interval;
    logic                         is_event;
    logic                         tick;
    logic                         start;
    logic                         step;
    logic                         period_hit;
    logic                         wrap;
    logic [AUX_N-1:0]             aux_hit;
    logic                         wr_period;
    logic [AUX_N-1:0]             wr_aux;
    logic [15:0]                  next_period;
    logic [AUX_N-1:0][15:0]       next_aux;

    // ------------------------------------------------------------------
    // Bus front end and event input
    // ------------------------------------------------------------------
    iec_ahb_slave u_bus (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .rd_data   (rd_data),
        .bus_req   (bus_req),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp)
    );

    iec_edge_sync u_event (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .pin_in     (trigger_event_input),
        .edge_sel   (ctrl.event_edge),
        .edge_pulse (ev_edge)
    );

    // ------------------------------------------------------------------
    // Count step selection
    // ------------------------------------------------------------------
    assign is_interval = ctrl.mode_select_field == MODE_INTERVAL;
    assign is_event    = ctrl.mode_select_field == MODE_EVENT;
    // Capture edge bits and option register feed nothing here [R17]
    assign tick = is_interval ? (ctrl.ext_event_clock_sel ? ev_edge : 1'b1) // [R18]
                : (is_event ? ev_edge : 1'b0);                               // [R8]
    assign start      = (state == IEC_ARMED) && ctrl.count_enable_bit && tick;
    assign step       = (state == IEC_RUN) && ctrl.count_enable_bit && tick;
    assign period_hit = step && (cnt == period_buf);               // [R19] [R10]
    assign wrap       = step && !period_hit && (cnt == CNT_IDLE);  // [R4] [R16]

    // Aux channel compare against its buffer
    always_comb begin
        for (int k = 0; k < AUX_N; k++) begin
            aux_hit[k] = step && (cnt == aux_buf[k]);              // [R6] [R7] [R11]
        end
    end

    // Write decode with the value about to be stored
    always_comb begin
        wr_period   = bus_req.wr && iec_hit(bus_req.addr, OFS_PERIOD);
        next_period = wr_period ? bus_req.wdata[15:0] : period_compare_reg;
        wr_aux[0]   = bus_req.wr && iec_hit(bus_req.addr, OFS_AUX1);
        wr_aux[1]   = bus_req.wr && iec_hit(bus_req.addr, OFS_AUX2);
        wr_aux[2]   = bus_req.wr && iec_hit(bus_req.addr, OFS_AUX3);
        for (int k = 0; k < AUX_N; k++) begin
            next_aux[k] = wr_aux[k] ? bus_req.wdata[15:0] : aux_compare_regs[k];
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl                 <= iec_ctrl_t'(CTRL_RST);
            period_compare_reg   <= PERIOD_RST;
            aux_compare_regs     <= {AUX_N{AUX_RST}};
            aux_match_mask_flags <= MASK_RST;
        end else begin
            if (bus_req.wr && iec_hit(bus_req.addr, OFS_CTRL)) begin
                ctrl <= iec_ctrl_t'(bus_req.wdata[CTRL_W-1:0]);
            end
            if (bus_req.wr && iec_hit(bus_req.addr, OFS_MASK)) begin
                aux_match_mask_flags <= bus_req.wdata[AUX_N-1:0];
            end
            period_compare_reg <= next_period;
            aux_compare_regs   <= next_aux;
        end
    end

    // Overflow flag, write one to clear, a new wrap wins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            overflow_flag <= 1'b0;
        end else if (wrap) begin
            overflow_flag <= 1'b1;                                 // [R4]
        end else if (bus_req.wr && iec_hit(bus_req.addr, OFS_OPTION)
                     && bus_req.wdata[OVF_BIT]) begin
            overflow_flag <= 1'b0;
        end
    end

    // Read mux; count reads zero unless running
    always_comb begin
        rd_data = 32'h0000_0000;
        if (iec_hit(bus_req.addr, OFS_CTRL)) begin
            rd_data[CTRL_W-1:0] = ctrl;
        end else if (iec_hit(bus_req.addr, OFS_PERIOD)) begin
            rd_data[15:0] = period_compare_reg;
        end else if (iec_hit(bus_req.addr, OFS_AUX1)) begin
            rd_data[15:0] = aux_compare_regs[0];
        end else if (iec_hit(bus_req.addr, OFS_AUX2)) begin
            rd_data[15:0] = aux_compare_regs[1];
        end else if (iec_hit(bus_req.addr, OFS_AUX3)) begin
            rd_data[15:0] = aux_compare_regs[2];
        end else if (iec_hit(bus_req.addr, OFS_COUNT)) begin
            rd_data[15:0] = (state == IEC_RUN) ? cnt : CNT_ZERO;
        end else if (iec_hit(bus_req.addr, OFS_OPTION)) begin
            rd_data[OVF_BIT] = overflow_flag;
        end else if (iec_hit(bus_req.addr, OFS_MASK)) begin
            rd_data[AUX_N-1:0] = aux_match_mask_flags;
        end
    end

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= IEC_IDLE;
        end else begin
            case (state)
                IEC_IDLE: begin
                    if (ctrl.count_enable_bit) begin
                        state <= IEC_ARMED;
                    end
                end
                IEC_ARMED: begin
                    if (!ctrl.count_enable_bit) begin
                        state <= IEC_IDLE;                         // [R20]
                    end else if (tick) begin
                        state <= IEC_RUN;
                    end
                end
                IEC_RUN: begin
                    if (!ctrl.count_enable_bit) begin
                        state <= IEC_IDLE;                         // [R20]
                    end
                end
                default: state <= IEC_IDLE;
            endcase
        end
    end

    // Counter: idle at FFFFH, first tick clears, match clears
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt <= CNT_IDLE;
        end else if (!ctrl.count_enable_bit || state == IEC_IDLE) begin
            cnt <= CNT_IDLE;                                       // [R20]
        end else if (start || period_hit) begin
            cnt <= CNT_ZERO;                                       // [R1] [R9] [R2] [R15]
        end else if (step) begin
            cnt <= cnt + CNT_ONE;                                  // [R4] [R16]
        end
    end

    // Compare buffers: loaded at start and on any write while enabled
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            period_buf <= PERIOD_RST;
            aux_buf    <= {AUX_N{AUX_RST}};
        end else begin
            if (start || (wr_period && ctrl.count_enable_bit)) begin
                period_buf <= next_period;                         // [R3] [R9]
            end
            for (int k = 0; k < AUX_N; k++) begin
                if (start || (wr_aux[k] && ctrl.count_enable_bit)) begin
                    aux_buf[k] <= next_aux[k];                     // [R11]
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs and interrupt pulses
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            period_toggle_out <= 1'b0;
        end else if (is_interval && (start || period_hit)) begin
            period_toggle_out <= ~period_toggle_out;               // [R19] [R1]
        end
    end

    // Aux outputs toggle only where timer output is allowed
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aux_toggle_out <= '0;
        end else if (is_interval) begin
            aux_toggle_out <= aux_toggle_out ^ aux_hit;            // [R6]
        end
    end

    // One-cycle interrupt pulses
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            period_match_irq <= 1'b0;
            aux_match_irq    <= '0;
            overflow_irq     <= 1'b0;
        end else begin
            period_match_irq <= period_hit;                        // [R10] [R19]
            aux_match_irq    <= aux_hit & ~aux_match_mask_flags;   // [R11]
            overflow_irq     <= wrap;                              // [R2] [R15]
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_run_tick;
        (state == IEC_RUN) && ctrl.count_enable_bit && tick;
    endsequence

    sequence s_zero_match;
        s_run_tick ##0 (is_interval && period_buf == CNT_ZERO && cnt == CNT_ZERO);
    endsequence

    a_zero_period_hold: assert property (s_zero_match |=> period_match_irq && cnt == CNT_ZERO
        && period_toggle_out != $past(period_toggle_out)) // [R1]
        else $error("zero period did not match and hold");

    a_full_no_ovf: assert property (s_run_tick ##0 (cnt == CNT_IDLE && period_buf == CNT_IDLE)
        |=> cnt == CNT_ZERO && period_match_irq && !overflow_irq) // [R2] [R15]
        else $error("full period clear raised overflow");

    a_period_copy: assert property (wr_period && ctrl.count_enable_bit
        |=> period_buf == $past(bus_req.wdata[15:0])) // [R3]
        else $error("period write not copied to buffer");

    a_wrap_ovf: assert property (s_run_tick ##0 (cnt == CNT_IDLE && period_buf != CNT_IDLE)
        |=> cnt == CNT_ZERO && overflow_irq && !period_match_irq) // [R4] [R16]
        else $error("wrap did not clear with overflow");

    a_aux_toggle: assert property (s_run_tick ##0 (is_interval && cnt == aux_buf[0])
        |=> aux_toggle_out[0] != $past(aux_toggle_out[0])
            && aux_match_irq[0] == !aux_match_mask_flags[0]) // [R6] [R11]
        else $error("aux channel missed its match");

    a_aux_quiet: assert property (!aux_hit[0] |=> $stable(aux_toggle_out[0]) && !aux_match_irq[0]) // [R7]
        else $error("aux channel acted without a match");

    a_event_start: assert property ((state == IEC_ARMED) && ctrl.count_enable_bit && tick && is_event
        |=> cnt == CNT_ZERO && state == IEC_RUN && period_buf == $past(next_period)) // [R9]
        else $error("event start did not clear and load");

    a_event_match: assert property (s_run_tick ##0 (is_event && cnt == period_buf)
        |=> cnt == CNT_ZERO && period_match_irq && $stable(period_toggle_out)) // [R10] [R8]
        else $error("event match did not clear and interrupt");

    a_interval_toggle: assert property (s_run_tick ##0 (is_interval && cnt == period_buf)
        |=> cnt == CNT_ZERO ##0 period_toggle_out != $past(period_toggle_out)) // [R19] [R18]
        else $error("interval match did not toggle output");

    a_idle_hold: assert property (!ctrl.count_enable_bit |=> (state == IEC_IDLE
        && cnt == CNT_IDLE) ##1 (state != IEC_RUN && cnt == CNT_IDLE)) // [R20]
        else $error("counter ran while disabled");

endmodule
`default_nettype wire

//--- testbench/iec_event_src.sv
// Purpose : Pulse source that stands on the event input pin
// Assumes : Pin idles low; pulses are wide enough for the synchroniser
// Notes   : A go strobe starts a train of n_edges rising edges
`timescale 1ns/100ps
`default_nettype none
module iec_event_src (
    input  wire logic       sys_clk,
    input  wire logic [7:0] n_edges,
    input  wire logic       go,
    output var  logic       pin
);
    logic [7:0] left = 8'h00;
    logic [2:0] ph   = 3'h0;

    // Four clocks low, four high per edge, only on the event pin
    always_ff @(posedge sys_clk) begin
        if (go) begin
            left <= n_edges;
            ph   <= 3'h0;
        end else if (left != 8'h00) begin
            ph <= ph + 3'h1;
            if (ph == 3'h7) begin
                left <= left - 8'h01;
            end
        end
    end
    assign pin = (left != 8'h00) && ph[2]; // Low while idle
endmodule
`default_nettype wire

//--- testbench/iec_timer_tb.sv
// Purpose : Self-checking bench for the interval/event counter
// Assumes : Bus master waits on hready; event source drives the pin
// Notes   : Pulse and toggle counts are compared over fixed windows
`timescale 1ns/100ps
`default_nettype none
module iec_timer_tb
    import iec_pkg::*;
;
    localparam logic [31:0] zero = 32'h0000_0000;
    localparam logic [31:0] one  = 32'h0000_0001;
    logic             sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic             hreadyout, hresp, pin, period_toggle_out, period_match_irq, overflow_irq;
    logic             tg_q;
    logic [1:0]       htrans = 2'h0;
    logic [2:0]       hsize = HSIZE_WORD;
    logic [31:0]      haddr = zero, hwdata = zero, hrdata, q;
    logic [AUX_N-1:0] aux_toggle_out, aux_match_irq;
    int               n_mismatch = 0, cmp_count = 0, cyc = 0, n_pm, n_ax, n_ov, n_tg;

    always #5 sys_clk = ~sys_clk;

    iec_timer i_iec_timer (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trigger_event_input(pin),
        .period_toggle_out(period_toggle_out), .aux_toggle_out(aux_toggle_out),
        .period_match_irq(period_match_irq), .aux_match_irq(aux_match_irq),
        .overflow_irq(overflow_irq));
    iec_event_src i_iec_event_src (.sys_clk(sys_clk), .n_edges(8'h09), .go(go), .pin(pin));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Pulse counters, toggle counter and hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        tg_q <= period_toggle_out;
        if (rst) begin
            n_pm <= 0;
            n_ax <= 0;
            n_ov <= 0;
            n_tg <= 0;
        end else begin
            n_pm <= n_pm + int'(period_match_irq);
            n_ax <= n_ax + int'(aux_match_irq[0]);
            n_ov <= n_ov + int'(overflow_irq);
            n_tg <= n_tg + int'(period_toggle_out ^ tg_q);
        end
        if (cyc == 70000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One AHB-Lite single word transfer, held until hready is sampled high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0_0000, a};
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, zero);
        chk(q, e);
    endtask

    // Count match, aux match and toggle events over a window of c clocks
    task automatic win(input int c, input int pm, input int ax, input int tg);
        int p0, a0, t0;
        p0 = n_pm;
        a0 = n_ax;
        t0 = n_tg;
        repeat (c) @(posedge sys_clk);
        chk(n_pm - p0, pm);
        if (ax >= 0) chk(n_ax - a0, ax);
        chk(n_tg - t0, tg);
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rc(OFS_COUNT, zero);
        rc(12'h100, zero);
        chk({31'h0, hresp}, zero);
        wr(OFS_PERIOD, 32'h0000_0002);
        wr(OFS_AUX1, one);
        wr(OFS_AUX2, 32'h0000_0005);
        wr(OFS_CTRL, one);
        repeat (10) @(posedge sys_clk);
        win(30, 10, 10, 10);
        chk({31'h0, aux_toggle_out[1]}, zero);
        wr(OFS_CTRL, zero);
        rc(OFS_COUNT, zero);
        wr(OFS_PERIOD, zero);
        wr(OFS_CTRL, one);
        repeat (10) @(posedge sys_clk);
        win(20, 20, 0, 20);
        rc(OFS_COUNT, zero);
        // Lowered period while running forces one full wrap
        wr(OFS_CTRL, zero);
        wr(OFS_PERIOD, 32'h0000_0064);
        wr(OFS_CTRL, one);
        repeat (60) @(posedge sys_clk);
        wr(OFS_PERIOD, 32'h0000_000A);
        win(65300, 0, 0, 0);
        repeat (300) @(posedge sys_clk);
        chk(n_ov, one);
        rc(OFS_OPTION, one);
        // Event count mode, rising edges, capture edge bits left 00
        wr(OFS_CTRL, zero);
        wr(OFS_PERIOD, 32'h0000_0003);
        wr(OFS_CTRL, 32'h0000_0083);
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        win(90, 2, 2, 0);
        // Interval mode clocked by event edges keeps the timer output
        wr(OFS_CTRL, zero);
        wr(OFS_CTRL, 32'h0000_0091);
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        win(90, 2, 2, 3);
        conclude();
    end
endmodule
`default_nettype wire
